// ### rtl/amb_alarm_backup.sv
// Purpose: alarm 0 compare with single/pulsed interrupt, and backup mode bus gating
// Assumes: time_*_i already hold the advanced time in the cycle tick_i is high
// Notes:   supply comparators arrive as synchronous levels; irq pin is open drain
`timescale 1ns/1ns
// Notes on behaviour
// - main supply below reset threshold: all serial bus traffic is ignored.
// - mode 0/0: trip-threshold switchover, no bus or memory in backup.
// - mode 0/1: switch when main below battery; on battery the bus needs both above reset.
// - mode 1/0: behaves exactly like mode 0/0.
// - mode 1/1: battery switch; bus only above max(reset, battery); no memory in backup.
// - interrupt mode 0 treats an alarm match as a single event.
// - alarm only raised while alarm0_enable (control bit 5) is set.
// - alarm registers hold enable in bit 7, BCD value below; disabled fields ignored.
// - alarm fires when time first equals all enabled fields as the clock advances.
// - seconds disabled: match happens as seconds roll 59 to 00 into minute.
// - alarm event sets status flag and pulls the interrupt pin low.
// - pulsed mode sets the flag every trigger; no clearing needed for more pulses.
// - interrupt mode 1 (control bit 7) selects pulsed repeating interrupts.
// - power-up comes up in standard battery switchover mode.
module amb_alarm_backup (
  // clock, reset, enable
  input  wire logic       clk_sys_i,
  input  wire logic       nrst_i,
  input  wire logic       ce_i,
  // internal register port
  input  wire logic       reg_wr_i,
  input  wire logic [3:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  // running time, BCD
  input  wire logic       tick_i,
  input  wire logic [7:0] time_sec_i,
  input  wire logic [7:0] time_min_i,
  input  wire logic [7:0] time_hour_i,
  input  wire logic [7:0] time_date_i,
  input  wire logic [7:0] time_mon_i,
  input  wire logic [7:0] time_wday_i,
  // supply comparators
  input  wire logic       vdd_above_reset_i,
  input  wire logic       vbat_above_reset_i,
  input  wire logic       vdd_below_vbat_i,
  input  wire logic       vdd_below_trip_i,
  // power gating outputs
  output logic            on_battery_o,
  output logic            bus_enable_o,
  output logic            mem_enable_o,
  // open-drain irq_freq_output pin
  input  wire logic       irq_pin_i,
  output logic            irq_out_o,
  output logic            irq_oe_o
);
  logic [7:0] alarm_q [amb_pkg::NUM_ALM];
  logic [7:0] time_now [amb_pkg::NUM_ALM];
  logic [amb_pkg::NUM_ALM-1:0] fld_hit;
  logic [amb_pkg::NUM_ALM-1:0] fld_en;
  logic       interrupt_mode_q;
  logic       alarm0_enable_q;
  logic       backup_switch_select_q;
  logic       battery_bus_inhibit_q;
  logic       alarm0_status_flag_q;
  logic       match_prev_q;
  logic [3:0] pulse_cnt_q;
  logic       match_all;
  logic       alarm_ev;
  logic       flag_clr;
  logic       on_bat_d;
  logic       bus_en_d;
  logic       mem_en_d;

  // one enabled field compares equal on the BCD value bits
  function automatic logic field_match(input logic [7:0] cmp, input logic [7:0] now);
    field_match = (cmp[6:0] == now[6:0]);
  endfunction : field_match

  assign time_now[0] = time_sec_i;
  assign time_now[1] = time_min_i;
  assign time_now[2] = time_hour_i;
  assign time_now[3] = time_date_i;
  assign time_now[4] = time_mon_i;
  assign time_now[5] = time_wday_i;

  // per-field compare; a disabled field counts as a hit
  for (genvar g = 0; g < amb_pkg::NUM_ALM; g++) begin : g_fld
    assign fld_en[g]  = alarm_q[g][amb_pkg::BIT_FIELD_EN];
    assign fld_hit[g] = !fld_en[g] || field_match(alarm_q[g], time_now[g]);
  end

  // all-disabled alarm never fires, otherwise it would hit every tick
  assign match_all = (&fld_hit) && (|fld_en);
  // evaluated only on a clock advance, so a minute match lands on the 59->00 roll
  assign alarm_ev  = ce_i && tick_i && alarm0_enable_q
                     && match_all && !match_prev_q;
  assign flag_clr  = reg_wr_i && (reg_addr_i == amb_pkg::OFS_STATUS)
                     && !reg_wdata_i[amb_pkg::BIT_AL0];

  // alarm compare registers
  always_ff @(posedge clk_sys_i) begin
    for (int i = 0; i < amb_pkg::NUM_ALM; i++) begin
      if (!nrst_i) begin
        alarm_q[i] <= amb_pkg::RST_ALM;
      end else if (ce_i && reg_wr_i && reg_addr_i == 4'(i)) begin
        alarm_q[i] <= reg_wdata_i;
      end
    end
  end

  // interrupt and backup control bits
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      interrupt_mode_q       <= amb_pkg::RST_INT_CTRL[amb_pkg::BIT_IM];
      alarm0_enable_q        <= amb_pkg::RST_INT_CTRL[amb_pkg::BIT_ALARM0_ENABLE];
      backup_switch_select_q <= amb_pkg::RST_BKP_CTRL[amb_pkg::BIT_BSW];
      battery_bus_inhibit_q  <= amb_pkg::RST_BKP_CTRL[amb_pkg::BIT_BATTERY_BUS_INHIBIT];
    end else if (ce_i && reg_wr_i) begin
      if (reg_addr_i == amb_pkg::OFS_INT_CTRL) begin
        interrupt_mode_q <= reg_wdata_i[amb_pkg::BIT_IM];
        alarm0_enable_q  <= reg_wdata_i[amb_pkg::BIT_ALARM0_ENABLE];
      end
      if (reg_addr_i == amb_pkg::OFS_BKP_CTRL) begin
        backup_switch_select_q <= reg_wdata_i[amb_pkg::BIT_BSW];
        battery_bus_inhibit_q  <= reg_wdata_i[amb_pkg::BIT_BATTERY_BUS_INHIBIT];
      end
    end
  end

  // first-equal tracking; a match held over several ticks fires once
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      match_prev_q <= 1'b0;
    end else if (ce_i && tick_i) begin
      match_prev_q <= match_all;
    end
  end

  // status flag: an event in the clearing cycle wins over the clear
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      alarm0_status_flag_q <= 1'b0;
    end else if (alarm_ev) begin
      alarm0_status_flag_q <= 1'b1;
    end else if (ce_i && flag_clr) begin
      alarm0_status_flag_q <= 1'b0;
    end
  end

  // pulse length counter for pulsed mode
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      pulse_cnt_q <= 4'h0;
    end else if (alarm_ev && interrupt_mode_q) begin
      pulse_cnt_q <= amb_pkg::IRQ_PULSE_CYC - 4'h1;
    end else if (ce_i && pulse_cnt_q != 4'h0) begin
      pulse_cnt_q <= pulse_cnt_q - 4'h1;
    end
  end

  // open-drain pin: drive low on event, then hold per mode
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      irq_oe_o <= 1'b0;
    end else if (ce_i) begin
      if (interrupt_mode_q) begin
        irq_oe_o <= alarm_ev || (pulse_cnt_q != 4'h0);
      end else begin
        irq_oe_o <= alarm_ev || (alarm0_status_flag_q && alarm0_enable_q
                    && !flag_clr);
      end
    end
  end

  // pin output value is always low; only the enable toggles
  always_ff @(posedge clk_sys_i) begin
    irq_out_o <= 1'b0;
  end

  // switchover and bus/memory gating per mode bits
  always_comb begin
    on_bat_d = backup_switch_select_q ? vdd_below_vbat_i : vdd_below_trip_i;
    bus_en_d = 1'b0;
    mem_en_d = 1'b0;
    if (vdd_above_reset_i) begin
      if (!backup_switch_select_q) begin
        // reset asserts before trip switchover, so backup never talks
        bus_en_d = !on_bat_d;
        mem_en_d = !on_bat_d;
      end else if (!battery_bus_inhibit_q) begin
        bus_en_d = !on_bat_d || vbat_above_reset_i;
        mem_en_d = bus_en_d;
      end else begin
        bus_en_d = !on_bat_d;
        mem_en_d = !on_bat_d;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      on_battery_o <= 1'b0;
      bus_enable_o <= 1'b0;
      mem_enable_o <= 1'b0;
    end else if (ce_i) begin
      on_battery_o <= on_bat_d;
      bus_enable_o <= bus_en_d;
      mem_enable_o <= mem_en_d;
    end
  end

  // register read data, registered; unmapped indices read zero
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (ce_i) begin
      reg_rdata_o <= 8'h00;
      if (reg_addr_i < 4'(amb_pkg::NUM_ALM)) begin
        reg_rdata_o <= alarm_q[reg_addr_i[2:0]];
      end else if (reg_addr_i == amb_pkg::OFS_INT_CTRL) begin
        reg_rdata_o[amb_pkg::BIT_IM]   <= interrupt_mode_q;
        reg_rdata_o[amb_pkg::BIT_ALARM0_ENABLE] <= alarm0_enable_q;
      end else if (reg_addr_i == amb_pkg::OFS_BKP_CTRL) begin
        reg_rdata_o[amb_pkg::BIT_BSW]  <= backup_switch_select_q;
        reg_rdata_o[amb_pkg::BIT_BATTERY_BUS_INHIBIT] <= battery_bus_inhibit_q;
      end else if (reg_addr_i == amb_pkg::OFS_STATUS) begin
        reg_rdata_o[amb_pkg::BIT_AL0]    <= alarm0_status_flag_q;
        reg_rdata_o[amb_pkg::BIT_ONBAT]  <= on_battery_o;
        reg_rdata_o[amb_pkg::BIT_IRQPIN] <= irq_pin_i;
      end
    end
  end

  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  sequence s_alarm_event;
    alarm_ev;
  endsequence
  sequence s_pulse_low;
    irq_oe_o [*8];
  endsequence

  a_flag_and_pin: assert property (s_alarm_event |=> alarm0_status_flag_q && irq_oe_o)
    else $error("alarm event did not set flag and pull pin low");
  a_pulse_width: assert property (s_alarm_event ##0 interrupt_mode_q |=> s_pulse_low)
    else $error("pulsed interrupt shorter than its length");
  a_pulse_repeat: assert property (s_alarm_event ##0 interrupt_mode_q ##0 alarm0_status_flag_q
                                   |=> pulse_cnt_q == 4'h7)
    else $error("pulse not restarted while flag still set");
  a_enable_gate: assert property ($rose(alarm0_status_flag_q) |-> $past(alarm0_enable_q))
    else $error("alarm flag rose with alarm disabled");
  a_first_equal: assert property (s_alarm_event |-> !match_prev_q && tick_i)
    else $error("alarm raised without a fresh match on a tick");
  a_single_hold: assert property (ce_i && !interrupt_mode_q && alarm0_status_flag_q
                                  && alarm0_enable_q && !flag_clr |=> irq_oe_o)
    else $error("single event pin released early");
  a_field_ignore: assert property (alarm_ev |-> (fld_en & ~fld_hit) == '0)
    else $error("alarm fired with an enabled field unequal");
  a_lvr_quiet: assert property (ce_i && !vdd_above_reset_i |=> !bus_enable_o && !mem_enable_o)
    else $error("bus enabled below reset threshold");
  a_std_backup: assert property (ce_i && !backup_switch_select_q && vdd_below_trip_i
                                 |=> on_battery_o && !bus_enable_o)
    else $error("standard mode talks in backup");
  a_legacy_bus: assert property (ce_i && backup_switch_select_q && !battery_bus_inhibit_q
                                 && vdd_above_reset_i && vbat_above_reset_i
                                 |=> bus_enable_o && mem_enable_o)
    else $error("legacy mode dropped bus above reset");
  a_inhibit_bus: assert property (ce_i && backup_switch_select_q && battery_bus_inhibit_q
                                  && vdd_below_vbat_i |=> !bus_enable_o && !mem_enable_o)
    else $error("inhibit mode talks below battery");
  a_powerup_std: assert property ($past(!nrst_i) |-> !backup_switch_select_q)
    else $error("not standard switchover after reset");
endmodule : amb_alarm_backup

// ### rtl/amb_pkg.sv
// Purpose: shared constants for the alarm 0 matcher and backup bus gating
// Assumes: register map is reached through the device's internal register port
// Notes:   offsets are 4-bit register indices
package amb_pkg;
  // register indices
  localparam logic [3:0] OFS_ALM_SEC  = 4'h0;
  localparam logic [3:0] OFS_ALM_MIN  = 4'h1;
  localparam logic [3:0] OFS_ALM_HOUR = 4'h2;
  localparam logic [3:0] OFS_ALM_DATE = 4'h3;
  localparam logic [3:0] OFS_ALM_MON  = 4'h4;
  localparam logic [3:0] OFS_ALM_WDAY = 4'h5;
  localparam logic [3:0] OFS_INT_CTRL = 4'h6;
  localparam logic [3:0] OFS_BKP_CTRL = 4'h7;
  localparam logic [3:0] OFS_STATUS   = 4'h8;
  localparam int         NUM_ALM      = 6;
  // field positions
  localparam int BIT_FIELD_EN = 7;   // per-field enable in each alarm register
  localparam int BIT_IM       = 7;   // interrupt_mode in interrupt control
  localparam int BIT_ALARM0_ENABLE     = 5;   // alarm0_enable in interrupt control
  localparam int BIT_BSW      = 0;   // backup_switch_select in backup control
  localparam int BIT_BATTERY_BUS_INHIBIT     = 1;   // battery_bus_inhibit in backup control
  localparam int BIT_AL0      = 0;   // alarm0_status_flag in status
  localparam int BIT_ONBAT    = 1;   // battery switchover state in status
  localparam int BIT_IRQPIN   = 2;   // sensed level of the interrupt pin
  // values after reset
  localparam logic [7:0] RST_ALM      = 8'h00;
  localparam logic [7:0] RST_INT_CTRL = 8'h00;
  localparam logic [7:0] RST_BKP_CTRL = 8'h00;  // standard switchover at power-up
  // pulse length of a pulsed-mode interrupt, in clock cycles
  localparam logic [3:0] IRQ_PULSE_CYC = 4'h8;
endpackage : amb_pkg

// ### tb/amb_alarm_backup_tb.sv
// Purpose: self-checking bench for alarm 0 matching and backup bus gating
// Assumes: inputs change on the falling edge, ce_i high except in the freeze check
// Notes:   supply comparators are driven as plain levels
`timescale 1ns/1ns
module amb_alarm_backup_tb;
  logic       clk = 1'b0, nrst = 1'b0, wr = 1'b0, tck = 1'b0, ce = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wd = 8'h00, rdata, t [6] = '{default: 8'h00};
  logic       ar = 1'b1, br = 1'b0, bv = 1'b0, bt = 1'b0;
  logic       on_bat, bus_en, mem_en, pin, irq_out, irq_oe;
  int         fail_count = 0, n_checks = 0;
  // 10 MHz system clock
  always #50 clk = ~clk;
  amb_alarm_backup dut (.clk_sys_i(clk), .nrst_i(nrst), .ce_i(ce), .reg_wr_i(wr),
    .reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdata), .tick_i(tck),
    .time_sec_i(t[0]), .time_min_i(t[1]), .time_hour_i(t[2]), .time_date_i(t[3]),
    .time_mon_i(t[4]), .time_wday_i(t[5]), .vdd_above_reset_i(ar),
    .vbat_above_reset_i(br), .vdd_below_vbat_i(bv), .vdd_below_trip_i(bt),
    .on_battery_o(on_bat), .bus_enable_o(bus_en), .mem_enable_o(mem_en),
    .irq_pin_i(pin), .irq_out_o(irq_out), .irq_oe_o(irq_oe));
  amb_pin_model pm (.irq_oe_i(irq_oe), .irq_out_i(irq_out), .pin_o(pin));
  // comparisons, one per result kind
  task chk1(input string nm, input logic e, input logic s);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %b seen %b", nm, e, s);
    end
  endtask : chk1
  task chk8(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk8
  // register port, all tasks start and end on a falling edge
  // one idle edge after each write so back-to-back calls never re-raise the strobe at once
  task wr_reg(input logic [3:0] a, input logic [7:0] d);
    addr = a; wd = d; wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    @(negedge clk);
  endtask : wr_reg
  task rd_reg(input logic [3:0] a, output logic [7:0] d);
    addr = a;
    @(negedge clk);
    d = rdata;
  endtask : rd_reg
  task tick(input logic [7:0] s, input logic [7:0] m);
    t = '{s, m, 8'h11, 8'h01, 8'h01, 8'h03}; tck = 1'b1;
    @(negedge clk);
    tck = 1'b0;
    @(negedge clk);
  endtask : tick
  // counts falling edges with the pin pulled low
  task count_low(output logic [7:0] n);
    n = 8'h00;
    for (int i = 0; i < 24; i++) begin
      if (irq_oe === 1'b1) n++;
      @(negedge clk);
    end
  endtask : count_low
  task test_reset;
    logic [7:0] d;
    for (int i = 0; i < 9; i++) begin
      rd_reg(i[3:0], d);
      chk8("reset reg", (i == 8) ? 8'h04 : 8'h00, d);
    end
    chk1("power-up bus", 1'b1, bus_en);
    chk1("power-up on_bat", 1'b0, on_bat);
    wr_reg(4'h9, 8'hFF);
    rd_reg(4'h9, d);
    chk8("unmapped", 8'h00, d);
    // a write while the clock enable is low must leave the register untouched
    ce = 1'b0;
    wr_reg(4'h0, 8'h85);
    ce = 1'b1;
    rd_reg(4'h0, d);
    chk8("frozen write", 8'h00, d);
    $display("test reset done");
  endtask : test_reset
  task test_gating;
    logic eo, eb;
    for (int m = 0; m < 4; m++) begin
      wr_reg(4'h7, {6'h00, m[1:0]});
      for (int c = 0; c < 16; c++) begin
        {bt, bv, br, ar} = c[3:0];
        @(negedge clk);
        @(negedge clk);
        eo = m[0] ? bv : bt;
        if (!m[0]) eb = ar & !eo;
        else if (!m[1]) eb = ar & (!eo | br);
        else eb = ar & !bv;
        chk1("on_battery", eo, on_bat);
        chk1("bus_enable", eb, bus_en);
        chk1("mem_enable", eb, mem_en);
      end
    end
    {bt, bv, br, ar} = 4'h1;
    $display("test gating done");
  endtask : test_gating
  task test_single;
    logic [7:0] d;
    wr_reg(4'h0, 8'h00);
    wr_reg(4'h1, 8'hB0);
    wr_reg(4'h2, 8'h91);
    wr_reg(4'h3, 8'h81);
    wr_reg(4'h4, 8'h81);
    wr_reg(4'h5, 8'h00);
    wr_reg(4'h6, 8'h00);
    tick(8'h59, 8'h29);
    tick(8'h00, 8'h30);
    chk1("irq, alarm disabled", 1'b0, irq_oe);
    wr_reg(4'h6, 8'h20);
    tick(8'h59, 8'h29);
    chk1("irq before rollover", 1'b0, irq_oe);
    tick(8'h00, 8'h30);
    chk1("irq at match", 1'b1, irq_oe);
    chk1("pin at match", 1'b0, pin);
    rd_reg(4'h8, d);
    chk1("flag at match", 1'b1, d[0]);
    tick(8'h01, 8'h30);
    // wait past a pulsed-mode length so only a held single event keeps the pin low
    repeat (10) @(negedge clk);
    chk1("irq held", 1'b1, irq_oe);
    wr_reg(4'h8, 8'h00);
    @(negedge clk);
    chk1("irq after clear", 1'b0, irq_oe);
    tick(8'h02, 8'h30);
    chk1("no repeat", 1'b0, irq_oe);
    $display("test single done");
  endtask : test_single
  task test_pulsed;
    logic [7:0] n, d;
    wr_reg(4'h0, 8'hB0);
    for (int i = 1; i < 6; i++) wr_reg(i[3:0], 8'h00);
    wr_reg(4'h6, 8'hA0);
    for (int k = 0; k < 2; k++) begin
      tick(8'h29, 8'h05);
      tick(8'h30, 8'h05);
      count_low(n);
      chk8("pulse length", 8'h08, n + 8'h01);
      rd_reg(4'h8, d);
      chk1("flag pulsed", 1'b1, d[0]);
    end
    $display("test pulsed done");
  endtask : test_pulsed
  // single place where the run ends
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  // watchdog: tests need about 270 cycles, allow over seventy times that
  initial begin
    #2000000;
    fail_count++;
    report_and_stop();
  end
  initial begin
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    repeat (2) @(negedge clk);
    test_reset();
    test_gating();
    test_single();
    test_pulsed();
    report_and_stop();
  end
endmodule : amb_alarm_backup_tb

// ### tb/amb_pin_model.sv
// Purpose: board side of the open-drain interrupt pin, a pull-up to the supply
// Assumes: design drives the pin only while irq_oe_i is high
// Notes:   released pin reads high, never the last driven value
`timescale 1ns/1ns
module amb_pin_model (
  // design drive
  input  wire logic irq_oe_i,
  input  wire logic irq_out_i,
  // wire level
  output logic      pin_o
);
  // pull-up wins whenever the design lets go
  assign pin_o = irq_oe_i ? irq_out_i : 1'b1;
endmodule : amb_pin_model
